// ---- svc_pkg.sv ----
package svc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and tick
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_NS         = 1000000;
    localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = 18;
    localparam int MS_W          = 19;
    localparam int BLEN_W        = 13;

    ////////////////////////////////////////////////////////////////////////////////
    // Times in milliseconds
    localparam int FCOOL_HOLD_MS   = 5000;
    localparam int LEARN_HOLD_MS   = 11000;
    localparam int BEEPCFG_HOLD_MS = 16000;
    localparam int HEAT_WINDOW_MS  = 300000;
    localparam int CFG_TIMEOUT_MS  = 20000;
    localparam int DIAG_RUN_MS     = 30000;
    localparam int MATCH_LED_MS    = 30000;
    localparam int MATCH_BEEP_MS   = 4000;
    localparam int MISS_LED_MS     = 500;
    localparam int BLINK_HALF_MS   = 500;
    localparam int SHORT_BEEP_MS   = 100;
    localparam int LONG_BEEP_MS    = 1000;
    localparam int BEEP_GAP_MS     = 100;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_STATUS    = 4'h4;
    localparam logic [3:0] REG_FAULT     = 4'h8;
    localparam int         CTRL_START    = 0;
    localparam int         CTRL_STOP     = 1;
    localparam int         ST_MODE_LSB   = 0;
    localparam int         ST_DIAG       = 8;
    localparam int         ST_FAULT      = 9;
    localparam int         ST_BLINK      = 10;
    localparam int         ST_BEEP_EN    = 11;
    localparam int         ST_TX_LSB     = 12;
    localparam int         ST_BRIGHT_LSB = 14;
    localparam int         ST_ARMED      = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset and default values
    localparam logic [1:0] TXCODE_DEFAULT  = 2'h0;
    localparam logic       BEEP_EN_DEFAULT = 1'b1;
    localparam logic [1:0] BRIGHT_DEFAULT  = 2'h0;
    localparam logic [7:0] NO_FAULT_CODE   = 8'h00;

    typedef enum logic [5:0] {
        MODE_OFF     = 6'h01,
        MODE_AUTO    = 6'h02,
        MODE_FCOOL   = 6'h04,
        MODE_FHEAT   = 6'h08,
        MODE_LEARN   = 6'h10,
        MODE_BEEPCFG = 6'h20
    } mode_t;

    typedef enum logic [2:0] {
        CMD_OPERATE              = 3'h0,
        CMD_UNIT_FACTORY_RESTORE = 3'h1,
        CMD_CHECK                = 3'h2,
        CMD_CHECK_LONG           = 3'h3,
        CMD_FAULT                = 3'h4,
        CMD_BRIGHT               = 3'h5
    } cmd_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] txcode;
        cmd_t       cmd;
        logic [7:0] fault;
    } frame_t;

    typedef struct packed {
        logic [1:0] txcode;
        logic       beep_en;
        logic [1:0] bright;
        logic       fault_valid;
        logic [7:0] fault_code;
    } nv_t;

endpackage : svc_pkg

// ---- beep_player.sv ----
`timescale 1ns/1ns
module beep_player (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        ms_tick,
    input  wire logic                        start,
    input  wire logic [2:0]                  count,
    input  wire logic [svc_pkg::BLEN_W-1:0]  len_ms,
    output logic                             buzz,
    output logic                             busy
);

    typedef struct packed {
        logic                       buzz;
        logic [2:0]                 left;
        logic [svc_pkg::BLEN_W-1:0] len;
        logic [svc_pkg::BLEN_W-1:0] cnt;
    } beep_state_t;

    localparam logic [svc_pkg::BLEN_W-1:0] GAP = svc_pkg::BLEN_W'(svc_pkg::BEEP_GAP_MS);

    beep_state_t s_r;
    beep_state_t s_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Beep train: count beeps of len_ms, gaps between
    always_comb begin
        s_nxt = s_r;
        if (start && count != 3'h0) begin
            s_nxt.buzz = 1'b1;
            s_nxt.left = count;
            s_nxt.len  = len_ms;
            s_nxt.cnt  = '0;
        end else if (s_r.left != 3'h0 && ms_tick) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
            if (s_r.buzz && s_nxt.cnt >= s_r.len) begin
                s_nxt.buzz = 1'b0;
                s_nxt.cnt  = '0;
                s_nxt.left = s_r.left - 1'b1;
            end else if (!s_r.buzz && s_nxt.cnt >= GAP) begin
                s_nxt.buzz = 1'b1;
                s_nxt.cnt  = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign buzz = s_r.buzz;
    assign busy = (s_r.left != 3'h0);

endmodule : beep_player

// ---- service_button_and_fault_diag.sv ----
`timescale 1ns/1ns
module service_button_and_fault_diag #(
    parameter int TICK_CYCLES     = svc_pkg::TICK_CYCLES,
    parameter int FCOOL_HOLD_MS   = svc_pkg::FCOOL_HOLD_MS,
    parameter int LEARN_HOLD_MS   = svc_pkg::LEARN_HOLD_MS,
    parameter int BEEPCFG_HOLD_MS = svc_pkg::BEEPCFG_HOLD_MS,
    parameter int HEAT_WINDOW_MS  = svc_pkg::HEAT_WINDOW_MS,
    parameter int CFG_TIMEOUT_MS  = svc_pkg::CFG_TIMEOUT_MS,
    parameter int DIAG_RUN_MS     = svc_pkg::DIAG_RUN_MS,
    parameter int MATCH_LED_MS    = svc_pkg::MATCH_LED_MS
) (
    input  wire logic             CLK,
    input  wire logic             RSTN,
    input  wire logic             BUTTON,
    input  wire logic             UNIT_RESET_BTN,
    input  wire svc_pkg::frame_t  FRAME,
    input  wire logic             FAULT_EVT,
    input  wire logic [7:0]       FAULT_CODE,
    input  wire logic             BREAKDOWN,
    input  wire svc_pkg::nv_t     NV_IN,
    input  wire logic [3:0]       ADDR,
    input  wire logic [31:0]      WDATA,
    input  wire logic             WR,
    input  wire logic             RD,
    output logic [31:0]           RDATA,
    output svc_pkg::mode_t        MODE,
    output logic                  TIMER_LED,
    output logic                  POWER_LED,
    output logic                  BUZZER,
    output logic                  NV_WE,
    output svc_pkg::nv_t          NV_OUT
);

    localparam int MW = svc_pkg::MS_W;
    localparam int BW = svc_pkg::BLEN_W;

    typedef struct packed {
        logic [2:0]                 btn_sync;
        logic [2:0]                 rst_sync;
        logic                       btn;
        logic                       rstb;
        logic [svc_pkg::TICK_W-1:0] tick_cnt;
        logic                       ms_tick;
        logic [MW-1:0]              hold_ms;
        svc_pkg::mode_t             mode;
        logic [MW-1:0]              mode_ms;
        logic                       armed;
        logic                       diag;
        logic [MW-1:0]              run_ms;
        logic                       pled;
        logic [MW-1:0]              pled_ms;
        logic                       blink;
        logic                       tled;
        logic [MW-1:0]              blink_ms;
        svc_pkg::nv_t               nv;
        logic                       nv_we;
        logic                       loaded;
        logic [31:0]                rdata;
        logic                       bstart;
        logic [2:0]                 bcount;
        logic [BW-1:0]              blen;
    } ctl_state_t;

    ctl_state_t s_r;
    ctl_state_t s_nxt;
    logic       buzz;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic reached(input logic [MW-1:0] cnt, input int lim);
        reached = (cnt >= MW'(lim));
    endfunction : reached

    function automatic logic [MW-1:0] bump(input logic [MW-1:0] cnt);
        bump = (cnt == {MW{1'b1}}) ? cnt : cnt + 1'b1;
    endfunction : bump

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic press;
        logic hit_cool;
        logic hit_learn;
        logic hit_cfg;
        logic accept;
        logic start_op;
        logic stop_op;
        logic clr_led;
        press     = 1'b0;
        hit_cool  = 1'b0;
        hit_learn = 1'b0;
        hit_cfg   = 1'b0;
        accept    = 1'b0;
        start_op  = 1'b0;
        stop_op   = 1'b0;
        clr_led   = 1'b0;
        s_nxt = s_r;
        s_nxt.bstart = 1'b0;
        s_nxt.nv_we  = 1'b0;
        s_nxt.rdata  = 32'h0000_0000;

        // Pin synchronisers, change taken when stages two and three agree
        s_nxt.btn_sync = {s_r.btn_sync[1:0], BUTTON};
        s_nxt.rst_sync = {s_r.rst_sync[1:0], UNIT_RESET_BTN};
        if (s_r.btn_sync[1] == s_r.btn_sync[2]) begin
            s_nxt.btn = s_r.btn_sync[2];
        end
        if (s_r.rst_sync[1] == s_r.rst_sync[2]) begin
            s_nxt.rstb = s_r.rst_sync[2];
        end
        press = s_nxt.btn && !s_r.btn;

        // Millisecond tick
        s_nxt.ms_tick = 1'b0;
        if (s_r.tick_cnt == svc_pkg::TICK_W'(TICK_CYCLES - 1)) begin
            s_nxt.tick_cnt = '0;
            s_nxt.ms_tick  = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
        end

        // Hold timer
        if (!s_r.btn) begin
            s_nxt.hold_ms = '0;
        end else if (s_r.ms_tick) begin
            s_nxt.hold_ms = bump(s_r.hold_ms);
            hit_cool  = (s_r.hold_ms == MW'(FCOOL_HOLD_MS - 1));
            hit_learn = (s_r.hold_ms == MW'(LEARN_HOLD_MS - 1));
            hit_cfg   = (s_r.hold_ms == MW'(BEEPCFG_HOLD_MS - 1));
        end

        // Mode, run and LED timers
        if (s_r.ms_tick) begin
            s_nxt.mode_ms = bump(s_r.mode_ms);
            if (s_r.pled_ms != '0) begin
                s_nxt.pled_ms = s_r.pled_ms - 1'b1;
            end
            if (s_r.diag && s_r.mode != svc_pkg::MODE_OFF) begin
                s_nxt.run_ms = bump(s_r.run_ms);
            end
            if (reached(s_r.blink_ms, svc_pkg::BLINK_HALF_MS - 1)) begin
                s_nxt.blink_ms = '0;
                s_nxt.tled     = s_r.blink && !s_r.tled;
            end else begin
                s_nxt.blink_ms = s_r.blink_ms + 1'b1;
            end
        end
        if (!s_r.blink) begin
            s_nxt.tled = 1'b0;
        end
        s_nxt.pled = (s_nxt.pled_ms != '0);

        // Stored record caught once after reset release
        if (!s_r.loaded) begin
            s_nxt.loaded = 1'b1;
            s_nxt.nv     = NV_IN;
        end

        // Register port
        if (WR && ADDR == svc_pkg::REG_CTRL) begin
            start_op = WDATA[svc_pkg::CTRL_START];
            stop_op  = WDATA[svc_pkg::CTRL_STOP];
        end
        if (RD) begin
            case (ADDR)
                svc_pkg::REG_STATUS: begin
                    s_nxt.rdata[svc_pkg::ST_MODE_LSB +: 6]   = s_r.mode;
                    s_nxt.rdata[svc_pkg::ST_DIAG]            = s_r.diag;
                    s_nxt.rdata[svc_pkg::ST_FAULT]           = s_r.nv.fault_valid;
                    s_nxt.rdata[svc_pkg::ST_BLINK]           = s_r.blink;
                    s_nxt.rdata[svc_pkg::ST_BEEP_EN]         = s_r.nv.beep_en;
                    s_nxt.rdata[svc_pkg::ST_TX_LSB +: 2]     = s_r.nv.txcode;
                    s_nxt.rdata[svc_pkg::ST_BRIGHT_LSB +: 2] = s_r.nv.bright;
                    s_nxt.rdata[svc_pkg::ST_ARMED]           = s_r.armed;
                end
                svc_pkg::REG_FAULT: begin
                    s_nxt.rdata[7:0] = s_r.nv.fault_code;
                end
                default: begin
                    s_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Button actions
        if (press) begin
            case (s_r.mode)
                svc_pkg::MODE_BEEPCFG: begin
                    s_nxt.mode_ms = '0;
                    if (s_r.armed) begin
                        s_nxt.nv.beep_en = !s_r.nv.beep_en;
                        s_nxt.nv_we      = 1'b1;
                        s_nxt.bstart     = 1'b1;
                        s_nxt.bcount     = 3'h1;
                        s_nxt.blen       = s_r.nv.beep_en ? BW'(svc_pkg::SHORT_BEEP_MS)
                                                          : BW'(svc_pkg::LONG_BEEP_MS);
                    end
                end
                svc_pkg::MODE_FCOOL, svc_pkg::MODE_FHEAT, svc_pkg::MODE_LEARN: begin
                    s_nxt.mode = s_r.mode;
                end
                default: begin
                    start_op = 1'b1;
                end
            endcase
        end
        if (s_r.mode != svc_pkg::MODE_BEEPCFG) begin
            if (hit_cool) begin
                s_nxt.bstart = 1'b1;
                s_nxt.blen   = BW'(svc_pkg::SHORT_BEEP_MS);
                s_nxt.mode_ms = '0;
                if (s_r.mode == svc_pkg::MODE_FCOOL && !reached(s_r.mode_ms, HEAT_WINDOW_MS)) begin
                    s_nxt.mode   = svc_pkg::MODE_FHEAT;
                    s_nxt.bcount = 3'h2;
                end else begin
                    s_nxt.mode   = svc_pkg::MODE_FCOOL;
                    s_nxt.bcount = 3'h1;
                end
            end
            if (hit_learn) begin
                s_nxt.mode   = svc_pkg::MODE_LEARN;
                s_nxt.armed  = 1'b0;
                s_nxt.bstart = 1'b1;
                s_nxt.bcount = 3'h3;
                s_nxt.blen   = BW'(svc_pkg::SHORT_BEEP_MS);
            end
            if (hit_cfg) begin
                s_nxt.mode    = svc_pkg::MODE_BEEPCFG;
                s_nxt.armed   = 1'b0;
                s_nxt.mode_ms = '0;
                s_nxt.bstart  = 1'b1;
                s_nxt.bcount  = 3'h4;
                s_nxt.blen    = BW'(svc_pkg::SHORT_BEEP_MS);
            end
        end
        if (s_r.mode == svc_pkg::MODE_BEEPCFG && reached(s_r.mode_ms, CFG_TIMEOUT_MS)) begin
            s_nxt.mode  = svc_pkg::MODE_OFF;
            s_nxt.armed = 1'b0;
        end

        // Remote frames
        accept = FRAME.valid && (FRAME.txcode == s_r.nv.txcode || s_r.mode == svc_pkg::MODE_LEARN);
        if (accept) begin
            if (s_r.nv.beep_en) begin
                s_nxt.bstart = 1'b1;
                s_nxt.bcount = 3'h1;
                s_nxt.blen   = BW'(svc_pkg::SHORT_BEEP_MS);
            end
            if (s_r.mode == svc_pkg::MODE_LEARN && s_r.armed
                && FRAME.cmd != svc_pkg::CMD_UNIT_FACTORY_RESTORE) begin
                s_nxt.nv.txcode = FRAME.txcode;
                s_nxt.nv_we     = 1'b1;
                s_nxt.mode      = svc_pkg::MODE_OFF;
                s_nxt.armed     = 1'b0;
            end else begin
                case (FRAME.cmd)
                    svc_pkg::CMD_UNIT_FACTORY_RESTORE: begin
                        if (s_r.mode == svc_pkg::MODE_LEARN || s_r.mode == svc_pkg::MODE_BEEPCFG) begin
                            s_nxt.armed = 1'b1;
                        end else begin
                            s_nxt.nv.txcode  = svc_pkg::TXCODE_DEFAULT;
                            s_nxt.nv.beep_en = svc_pkg::BEEP_EN_DEFAULT;
                            s_nxt.nv.bright  = svc_pkg::BRIGHT_DEFAULT;
                            s_nxt.nv_we      = 1'b1;
                        end
                    end
                    svc_pkg::CMD_OPERATE: begin
                        start_op = (s_r.mode == svc_pkg::MODE_OFF);
                    end
                    svc_pkg::CMD_BRIGHT: begin
                        s_nxt.nv.bright = s_r.nv.bright + 1'b1;
                        s_nxt.nv_we     = 1'b1;
                    end
                    svc_pkg::CMD_CHECK: begin
                        if (s_r.mode == svc_pkg::MODE_FCOOL) begin
                            s_nxt.nv.fault_valid = 1'b0;
                            s_nxt.nv.fault_code  = svc_pkg::NO_FAULT_CODE;
                            s_nxt.nv_we          = 1'b1;
                            s_nxt.bstart         = 1'b1;
                            s_nxt.bcount         = 3'h1;
                            s_nxt.blen           = BW'(svc_pkg::SHORT_BEEP_MS);
                        end
                    end
                    svc_pkg::CMD_CHECK_LONG: begin
                        s_nxt.diag   = !s_r.diag;
                        s_nxt.run_ms = '0;
                        s_nxt.bstart = 1'b0;
                    end
                    svc_pkg::CMD_FAULT: begin
                        if (s_r.diag) begin
                            s_nxt.bstart = 1'b0;
                            if (FRAME.fault == svc_pkg::NO_FAULT_CODE && !s_r.nv.fault_valid) begin
                                s_nxt.pled_ms = MW'(MATCH_LED_MS);
                                s_nxt.bstart  = 1'b1;
                                s_nxt.bcount  = 3'h3;
                                s_nxt.blen    = BW'(svc_pkg::SHORT_BEEP_MS);
                            end else if (s_r.nv.fault_valid && FRAME.fault == s_r.nv.fault_code) begin
                                s_nxt.pled_ms = MW'(MATCH_LED_MS);
                                s_nxt.bstart  = 1'b1;
                                s_nxt.bcount  = 3'h1;
                                s_nxt.blen    = BW'(svc_pkg::MATCH_BEEP_MS);
                            end else begin
                                s_nxt.pled_ms = MW'(svc_pkg::MISS_LED_MS);
                            end
                            s_nxt.pled = 1'b1;
                        end
                    end
                    default: begin
                        s_nxt.diag = s_r.diag;
                    end
                endcase
            end
        end
        if (s_r.diag && reached(s_r.run_ms, DIAG_RUN_MS)) begin
            s_nxt.diag = 1'b0;
        end

        // Start and stop of operation
        if (start_op && (s_r.mode == svc_pkg::MODE_OFF || s_r.mode == svc_pkg::MODE_AUTO)) begin
            s_nxt.mode  = svc_pkg::MODE_AUTO;
            s_nxt.blink = BREAKDOWN;
        end
        if (stop_op) begin
            s_nxt.mode  = svc_pkg::MODE_OFF;
            s_nxt.armed = 1'b0;
            clr_led     = 1'b1;
        end
        if (s_nxt.rstb && !s_r.rstb) begin
            clr_led = 1'b1;
        end
        if (clr_led) begin
            s_nxt.blink = 1'b0;
        end

        // Abnormality wins over other mode, blink and fault record updates this cycle
        if (FAULT_EVT) begin
            s_nxt.mode           = svc_pkg::MODE_OFF;
            s_nxt.blink          = 1'b1;
            s_nxt.nv.fault_valid = 1'b1;
            s_nxt.nv.fault_code  = FAULT_CODE;
            s_nxt.nv_we          = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s_r            <= '0;
            s_r.mode       <= svc_pkg::MODE_OFF;
            s_r.nv.txcode  <= svc_pkg::TXCODE_DEFAULT;
            s_r.nv.beep_en <= svc_pkg::BEEP_EN_DEFAULT;
            s_r.nv.bright  <= svc_pkg::BRIGHT_DEFAULT;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Buzzer
    beep_player u_beep (
        .clk     (CLK),
        .rstn    (RSTN),
        .ms_tick (s_r.ms_tick),
        .start   (s_r.bstart),
        .count   (s_r.bcount),
        .len_ms  (s_r.blen),
        .buzz    (buzz),
        .busy    ()
    );

    assign RDATA     = s_r.rdata;
    assign MODE      = s_r.mode;
    assign TIMER_LED = s_r.tled;
    assign POWER_LED = s_r.pled;
    assign BUZZER    = buzz;
    assign NV_WE     = s_r.nv_we;
    assign NV_OUT    = s_r.nv;

endmodule : service_button_and_fault_diag

// ---- svc_asserts.sv ----
`timescale 1ns/1ns
module svc_asserts (
    input wire logic            CLK,
    input wire logic            RSTN,
    input wire logic            UNIT_RESET_BTN,
    input wire svc_pkg::frame_t FRAME,
    input wire logic            FAULT_EVT,
    input wire logic [7:0]      FAULT_CODE,
    input wire svc_pkg::mode_t  MODE,
    input wire logic            TIMER_LED,
    input wire logic            BUZZER,
    input wire logic            NV_WE,
    input wire svc_pkg::nv_t    NV_OUT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    logic fr_ok;
    assign fr_ok = FRAME.valid && FRAME.txcode == NV_OUT.txcode && !FAULT_EVT;
    sequence s_rst_press;
        $rose(UNIT_RESET_BTN) ##1 (UNIT_RESET_BTN && !FAULT_EVT) [*6];
    endsequence
    a_fault_stops: assert property (FAULT_EVT |=> MODE == svc_pkg::MODE_OFF && NV_WE)
        else $error("fault did not stop operation");
    a_fault_kept: assert property (FAULT_EVT |=> NV_OUT.fault_valid && NV_OUT.fault_code == $past(FAULT_CODE))
        else $error("fault code not kept");
    a_code_filter: assert property (FRAME.valid && FRAME.txcode != NV_OUT.txcode && !FAULT_EVT
        && !(MODE inside {svc_pkg::MODE_LEARN, svc_pkg::MODE_BEEPCFG}) |=> !NV_WE)
        else $error("foreign frame obeyed");
    a_check_clears: assert property (fr_ok && FRAME.cmd == svc_pkg::CMD_CHECK && MODE == svc_pkg::MODE_FCOOL
        |=> NV_WE && !NV_OUT.fault_valid)
        else $error("check did not clear fault");
    a_cool_beep: assert property ($rose(MODE == svc_pkg::MODE_FCOOL) |-> ##[0:4] BUZZER)
        else $error("no beep on forced cooling");
    a_heat_from_cool: assert property ($rose(MODE == svc_pkg::MODE_FHEAT) |-> $past(MODE) == svc_pkg::MODE_FCOOL)
        else $error("heating not from cooling");
    a_learn_beep: assert property ($rose(MODE == svc_pkg::MODE_LEARN) |-> ##[0:4] BUZZER)
        else $error("no beep on learning");
    a_cfg_beep: assert property ($rose(MODE == svc_pkg::MODE_BEEPCFG) |-> ##[0:4] BUZZER)
        else $error("no beep on beep setup");
    a_reset_dark: assert property (s_rst_press |=> !TIMER_LED)
        else $error("reset button left LED on");
endmodule : svc_asserts
bind service_button_and_fault_diag svc_asserts u_chk (.CLK, .RSTN, .UNIT_RESET_BTN, .FRAME, .FAULT_EVT,
    .FAULT_CODE, .MODE, .TIMER_LED, .BUZZER, .NV_WE, .NV_OUT);

// ---- rc_model.sv ----
`timescale 1ns/1ns
module rc_model (
    input  wire logic       clk,
    output svc_pkg::frame_t frame,
    output logic            button
);
    initial begin
        frame  = '0;
        button = 1'b0;
    end
    task automatic send(input svc_pkg::cmd_t c, input logic [1:0] tx, input logic [7:0] f);
        @(posedge clk) frame <= '{1'b1, tx, c, f};
        @(posedge clk) frame.valid <= 1'b0;
    endtask : send
    task automatic hold(input int ms);
        @(posedge clk) button <= 1'b1;
        repeat (ms * 4) @(posedge clk);
        button <= 1'b0;
        repeat (40) @(posedge clk);
        #1;
    endtask : hold
    task automatic bright(input logic [1:0] tx);
        repeat (20) @(posedge clk);
        send(svc_pkg::CMD_BRIGHT, tx, 8'h00);
    endtask : bright
endmodule : rc_model

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    logic            clk, rstn, ubtn, fevt, brk, wr, rd, tled, pled, buz, nvwe, button;
    logic [7:0]      fcode;
    logic [3:0]      addr;
    logic [31:0]     wdata, rdata;
    svc_pkg::mode_t  mode;
    svc_pkg::nv_t    nvo, nvi;
    svc_pkg::frame_t frame;
    int              fail_count = 0, checked = 0;
    rc_model rc (.clk(clk), .frame(frame), .button(button));
    service_button_and_fault_diag #(.TICK_CYCLES(4), .FCOOL_HOLD_MS(5), .LEARN_HOLD_MS(11), .BEEPCFG_HOLD_MS(16),
        .HEAT_WINDOW_MS(50), .CFG_TIMEOUT_MS(20), .DIAG_RUN_MS(30), .MATCH_LED_MS(30)) dut (
        .CLK(clk), .RSTN(rstn), .BUTTON(button), .UNIT_RESET_BTN(ubtn), .FRAME(frame), .FAULT_EVT(fevt),
        .FAULT_CODE(fcode), .BREAKDOWN(brk), .NV_IN(nvi), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .MODE(mode), .TIMER_LED(tled), .POWER_LED(pled), .BUZZER(buz), .NV_WE(nvwe), .NV_OUT(nvo));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic conclude;
        $display("Checked %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    initial begin
        #400000;
        fail_count++;
        conclude();
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : w
    task automatic wrc(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk) wr <= 1'b0;
    endtask : wrc
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk) rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rdc
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, ubtn, fevt, brk, wr, rd, fcode, addr, wdata} = '0;
        nvi = 14'h0800;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        w(2);
        rdc(svc_pkg::REG_STATUS, 32'h0000_0801);
        wrc(svc_pkg::REG_STATUS, 32'hFFFF_FFFF);
        rdc(svc_pkg::REG_STATUS, 32'h0000_0801);
        rdc(4'hC, 32'h0000_0000);
        $display("Test registers finished");
        wrc(svc_pkg::REG_CTRL, 32'h0000_0001);
        @(posedge clk) {fevt, fcode} <= {1'b1, 8'h42};
        @(posedge clk) fevt <= 1'b0;
        w(1);
        chk(mode, svc_pkg::MODE_OFF);
        rdc(svc_pkg::REG_FAULT, 32'h0000_0042);
        rc.send(svc_pkg::CMD_CHECK_LONG, 2'h0, 8'h00);
        rdc(svc_pkg::REG_STATUS, 32'h0000_0F01);
        rc.send(svc_pkg::CMD_FAULT, 2'h0, 8'h42);
        w(60);
        chk(pled, 1'b1);
        w(100);
        chk({pled, buz}, 2'b01);
        rc.send(svc_pkg::CMD_FAULT, 2'h0, 8'h43);
        w(1000);
        chk(pled, 1'b1);
        w(1100);
        chk({pled, tled}, 2'b01);
        rc.send(svc_pkg::CMD_CHECK_LONG, 2'h0, 8'h00);
        rdc(svc_pkg::REG_STATUS, 32'h0000_0E01);
        @(posedge clk) ubtn <= 1'b1;
        w(12);
        @(posedge clk) {ubtn, brk} <= 2'b01;
        rdc(svc_pkg::REG_STATUS, 32'h0000_0A01);
        chk(tled, 1'b0);
        rc.hold(2);
        rdc(svc_pkg::REG_STATUS, 32'h0000_0E02);
        $display("Test diagnosis finished");
        @(posedge clk) brk <= 1'b0;
        rc.hold(8);
        chk(mode, svc_pkg::MODE_FCOOL);
        rdc(svc_pkg::REG_STATUS, 32'h0000_0A04);
        rc.send(svc_pkg::CMD_CHECK, 2'h0, 8'h00);
        w(2);
        chk(nvo.fault_valid, 1'b0);
        rc.hold(8);
        chk(mode, svc_pkg::MODE_FHEAT);
        wrc(svc_pkg::REG_CTRL, 32'h0000_0002);
        rc.send(svc_pkg::CMD_UNIT_FACTORY_RESTORE, 2'h1, 8'h00);
        rc.hold(13);
        chk(mode, svc_pkg::MODE_LEARN);
        rc.send(svc_pkg::CMD_UNIT_FACTORY_RESTORE, 2'h0, 8'h00);
        rc.send(svc_pkg::CMD_OPERATE, 2'h2, 8'h00);
        w(3);
        chk(nvo.txcode, 2'h2);
        rc.hold(18);
        chk(mode, svc_pkg::MODE_BEEPCFG);
        rc.send(svc_pkg::CMD_UNIT_FACTORY_RESTORE, 2'h2, 8'h00);
        rc.hold(2);
        chk(nvo.beep_en, 1'b0);
        w(10);
        rc.hold(2);
        chk({mode, nvo.beep_en}, {svc_pkg::MODE_BEEPCFG, 1'b1});
        w(60);
        chk(mode, svc_pkg::MODE_OFF);
        rc.bright(2'h2);
        w(1);
        chk(nvo.bright, 2'h1);
        rc.send(svc_pkg::CMD_UNIT_FACTORY_RESTORE, 2'h2, 8'h00);
        w(3);
        chk({nvo.txcode, nvo.beep_en, nvo.bright}, 5'b00100);
        $display("Test service modes finished");
        rc.send(svc_pkg::CMD_OPERATE, 2'h0, 8'h00);
        rc.send(svc_pkg::CMD_CHECK_LONG, 2'h0, 8'h00);
        rc.send(svc_pkg::CMD_FAULT, 2'h0, 8'h00);
        w(2);
        chk({pled, buz}, 2'b11);
        w(500);
        chk({pled, buz}, 2'b00);
        w(500);
        chk({pled, buz}, 2'b01);
        rdc(svc_pkg::REG_STATUS, 32'h0000_0802);
        @(posedge clk) {rstn, nvi} <= {1'b0, 14'h355A};
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        w(2);
        rdc(svc_pkg::REG_STATUS, 32'h0000_B201);
        rdc(svc_pkg::REG_FAULT, 32'h0000_005A);
        $display("Test run end and reload finished");
        conclude();
    end
endmodule : tb_top
